// >>> ppl_loop.sv
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`default_nettype none
module ppl_loop #(
  parameter int TICK = ppl_pkg::TICK_CYC,
  parameter int NTERM = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ppl_pkg::ppl_contacts_t contacts,
  input wire logic [NTERM-1:0] in_terminal,
  input wire logic cmd_pulse,
  input wire logic cmd_dir,
  input wire logic enc_pulse,
  input wire logic enc_dir,
  output logic [31:0] speed_cmd,
  output logic [NTERM-1:0] out_terminal,
  output logic in_position_flag,
  output logic excess_error
);
  // ---------------------------------------------------------------
  // settings
  // ---------------------------------------------------------------
  logic src_q, wr_ok, awd_q, wd_q;
  logic [3:0] mon_q;
  logic [15:0] num_q, den_q;
  logic [7:0] kp_q, ff_q;
  logic [12:0] fftc_q;
  logic [14:0] inpos_q;
  logic [18:0] errlv_q;
  logic [11:0] decel_q;
  logic [7:0] term_fn_q [NTERM];
  logic [13:0] feed_lo_q [ppl_pkg::FEED_COUNT];
  logic [13:0] feed_hi_q [ppl_pkg::FEED_COUNT];
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [7:0] awa;
  logic [31:0] wd;
  // the last feed word tops the map; anything above answers error
  localparam logic [7:0] LAST_OFS = ppl_pkg::OFS_FEED
    + 8'(4 * (ppl_pkg::FEED_COUNT - 1));
  assign awa = awd_q ? aw_q : s_axi_awaddr;
  assign wd = wd_q ? w_q : s_axi_wdata;
  assign wr_ok = (awd_q | s_axi_awvalid) & (wd_q | s_axi_wvalid)
    & ~s_axi_bvalid;

  // address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awd_q <= 1'b0;
      wd_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ppl_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awd_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd_q <= 1'b1;
        w_q <= s_axi_wdata;
      end
      if (wr_ok) begin
        awd_q <= 1'b0;
        wd_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awa > LAST_OFS) ? ppl_pkg::RESP_SLVERR
          : ppl_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = ~awd_q & ~s_axi_bvalid;
  assign s_axi_wready = ~wd_q & ~s_axi_bvalid;

  // settings store; out-of-range values clamp, except monitor select which falls to off; whole-word writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_q <= 1'b0;
      mon_q <= ppl_pkg::MON_OFF;
      num_q <= ppl_pkg::RST_GEAR;
      den_q <= ppl_pkg::RST_GEAR;
      kp_q <= ppl_pkg::RST_KP;
      ff_q <= 8'h00;
      fftc_q <= 13'h0000;
      inpos_q <= ppl_pkg::RST_INPOS;
      errlv_q <= ppl_pkg::RST_ERRLV;
      decel_q <= 12'h000;
      for (int i = 0; i < NTERM; i++) term_fn_q[i] <= 8'h00;
      for (int i = 0; i < ppl_pkg::FEED_COUNT; i++) begin
        feed_lo_q[i] <= 14'h0000;
        feed_hi_q[i] <= 14'h0000;
      end
    end else if (wr_ok && s_axi_wstrb == 4'hf) begin
      case (awa)
        ppl_pkg::OFS_CTRL: begin
          src_q <= wd[0];
          mon_q <= (wd[11:8] > 4'h5) ? ppl_pkg::MON_OFF : wd[11:8];
        end
        ppl_pkg::OFS_GEAR: begin
          num_q <= {1'b0, wd[14:0]};
          den_q <= {1'b0, wd[30:16]};
        end
        ppl_pkg::OFS_GAIN: begin
          kp_q <= (wd[7:0] > ppl_pkg::KP_MAX) ? ppl_pkg::KP_MAX : wd[7:0];
          ff_q <= (wd[15:8] > ppl_pkg::FF_MAX) ? ppl_pkg::FF_MAX
            : wd[15:8];
        end
        ppl_pkg::OFS_FFTC: fftc_q <= (wd[12:0] > ppl_pkg::FFTC_MAX)
          ? ppl_pkg::FFTC_MAX : wd[12:0];
        ppl_pkg::OFS_INPOS: inpos_q <= wd[14:0];
        ppl_pkg::OFS_ERRLV: errlv_q <= (wd[18:0] > ppl_pkg::ERRLV_MAX)
          ? ppl_pkg::ERRLV_MAX : wd[18:0];
        ppl_pkg::OFS_DECEL: decel_q <= (wd[11:0] > ppl_pkg::DECEL_MAX)
          ? ppl_pkg::DECEL_MAX : wd[11:0];
        ppl_pkg::OFS_TERM: begin
          for (int i = 0; i < NTERM; i++) term_fn_q[i] <= wd[8*i +: 8];
        end
        default: begin
          for (int i = 0; i < ppl_pkg::FEED_COUNT; i++) begin
            if (awa == ppl_pkg::OFS_FEED + 8'(4 * i)) begin
              feed_lo_q[i] <= (wd[13:0] > ppl_pkg::DIGIT_MAX)
                ? ppl_pkg::DIGIT_MAX : wd[13:0];
              feed_hi_q[i] <= (wd[29:16] > ppl_pkg::DIGIT_MAX)
                ? ppl_pkg::DIGIT_MAX : wd[29:16];
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // position loop
  // ---------------------------------------------------------------
  logic [NTERM-1:0] term_in_sel;
  logic servo_on;
  genvar g;
  generate
    for (g = 0; g < NTERM; g++) begin : g_term
      assign term_in_sel[g] = (term_fn_q[g] == ppl_pkg::FN_SERVO_ON)
        & in_terminal[g];
    end
  endgenerate
  assign servo_on = |term_in_sel;

  ppl_pkg::ppl_state_t st_q;
  logic fwd_q, rev_q, dir_q;
  logic [27:0] remain_q;
  logic [31:0] acc_q; // gear remainder accumulator
  logic signed [31:0] droop_q, speed_q, ff_flt_q;
  logic [31:0] mag, tick_q, rate_q, rate_cnt_q, gsum, gcnt;
  logic gate;
  logic [11:0] stop_q;
  logic [3:0] idx;
  logic int_pulse, int_dir, raw_pulse, raw_dir, geared, ok_dir, stop_req;
  assign idx = {contacts.sel3, contacts.sel_high, contacts.sel_mid,
    contacts.sel_low};
  // stored mode: one internal pulse per clock while amount remains
  assign int_pulse = (st_q == ppl_pkg::ST_FEED) && (remain_q != 28'h0);
  assign int_dir = dir_q;
  assign raw_pulse = src_q ? cmd_pulse : int_pulse;
  assign raw_dir = src_q ? cmd_dir : int_dir;
  // open run contact blocks that direction in either mode
  assign ok_dir = raw_dir ? contacts.rev : contacts.fwd;
  assign gate = raw_pulse && ok_dir && servo_on && den_q != 16'h0000;
  assign gsum = acc_q + {16'h0000, num_q};
  // several counts per pulse when num beats den, none while den is zero
  assign gcnt = gate ? gsum / {16'h0000, den_q} : 32'h0;
  assign geared = gcnt != 32'h0;
  assign stop_req = (dir_q ? ~contacts.rev : ~contacts.fwd);

  // gear accumulator: pulse passes each time num sums past den
  always_ff @(posedge aclk) begin
    if (!aresetn) acc_q <= 32'h0;
    else if (gate) acc_q <= gsum % {16'h0000, den_q};
  end

  // stored feed sequencer, selection taken at run rising edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ppl_pkg::ST_IDLE;
      fwd_q <= 1'b0;
      rev_q <= 1'b0;
      dir_q <= 1'b0;
      remain_q <= 28'h0;
      stop_q <= 12'h000;
    end else begin
      fwd_q <= contacts.fwd;
      rev_q <= contacts.rev;
      case (st_q)
        ppl_pkg::ST_IDLE: begin
          if (!src_q && servo_on && idx != 4'h0 &&
              ((contacts.fwd && !fwd_q) || (contacts.rev && !rev_q))) begin
            st_q <= ppl_pkg::ST_FEED;
            dir_q <= ~(contacts.fwd && !fwd_q);
            // relative amount from current spot, no homing
            remain_q <= 28'(feed_hi_q[idx - 4'h1] * ppl_pkg::DIGIT_SCALE)
              + 28'(feed_lo_q[idx - 4'h1]);
          end
        end
        ppl_pkg::ST_FEED: begin
          if (stop_req || !servo_on) begin
            st_q <= ppl_pkg::ST_STOP;
            stop_q <= decel_q;
            remain_q <= 28'h0;
          end else if (remain_q == 28'h0) st_q <= ppl_pkg::ST_IDLE;
          else if (ok_dir) remain_q <= remain_q - 28'h1;
        end
        ppl_pkg::ST_STOP: begin
          if (stop_q == 12'h000) st_q <= ppl_pkg::ST_IDLE;
          else if (tick_q == 32'h0) stop_q <= stop_q - 12'h1;
        end
        default: st_q <= ppl_pkg::ST_IDLE;
      endcase
    end
  end

  // deviation counter: command up, feedback down
  always_ff @(posedge aclk) begin
    if (!aresetn) droop_q <= 32'sh0;
    else if (!servo_on) droop_q <= 32'sh0;
    else droop_q <= droop_q + (raw_dir ? -$signed(gcnt) : $signed(gcnt))
      - (enc_pulse ? (enc_dir ? -32'sh1 : 32'sh1) : 32'sh0);
  end
  assign mag = droop_q[31] ? 32'(-droop_q) : 32'(droop_q);

  // loop tick, command rate and feed-forward lag per tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_q <= 32'h0;
      rate_cnt_q <= 32'h0;
      rate_q <= 32'h0;
      ff_flt_q <= 32'sh0;
      speed_q <= 32'sh0;
    end else begin
      tick_q <= (tick_q == 32'(TICK - 1)) ? 32'h0 : tick_q + 32'h1;
      if (tick_q == 32'h0) begin
        rate_cnt_q <= gcnt;
        rate_q <= rate_cnt_q;
        // tc in ms equals tick count; zero passes straight through
        ff_flt_q <= ff_flt_q + (($signed(rate_q * ff_q) - ff_flt_q)
          / $signed({19'h0, fftc_q + 13'h1}));
        // kp times droop, per second; ff in pulses per tick times 1000
        speed_q <= $signed({24'h0, kp_q}) * droop_q
          + ff_flt_q * 32'sd10;
      end else rate_cnt_q <= rate_cnt_q + gcnt;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all registered
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_cmd <= 32'h0;
      in_position_flag <= 1'b0;
      excess_error <= 1'b0;
      out_terminal <= '0;
    end else begin
      speed_cmd <= servo_on ? speed_q : 32'h0;
      in_position_flag <= mag < {17'h0, inpos_q};
      // error is sticky until servo drops
      if (!servo_on) excess_error <= 1'b0;
      else if (errlv_q != ppl_pkg::ERRLV_OFF && mag > {13'h0, errlv_q})
        excess_error <= 1'b1;
      for (int i = 0; i < NTERM; i++)
        out_terminal[i] <= (term_fn_q[i] == ppl_pkg::FN_INPOS)
          & (mag < {17'h0, inpos_q});
    end
  end

  // read channel, one word per access
  logic [31:0] rd;
  always_comb begin
    rd = 32'h0;
    case (s_axi_araddr)
      ppl_pkg::OFS_CTRL: rd = {20'h0, mon_q, 7'h0, src_q};
      ppl_pkg::OFS_GEAR: rd = {den_q, num_q};
      ppl_pkg::OFS_GAIN: rd = {16'h0, ff_q, kp_q};
      ppl_pkg::OFS_FFTC: rd = {19'h0, fftc_q};
      ppl_pkg::OFS_INPOS: rd = {17'h0, inpos_q};
      ppl_pkg::OFS_ERRLV: rd = {13'h0, errlv_q};
      ppl_pkg::OFS_DECEL: rd = {20'h0, decel_q};
      ppl_pkg::OFS_TERM: for (int i = 0; i < NTERM; i++)
        rd[8*i +: 8] = term_fn_q[i];
      ppl_pkg::OFS_STAT: rd = {26'h0, st_q, servo_on, excess_error,
        in_position_flag};
      ppl_pkg::OFS_DROOP: rd = droop_q;
      ppl_pkg::OFS_SPEED: rd = speed_q;
      ppl_pkg::OFS_MON: rd = (mon_q == 4'h0) ? droop_q
        : (mon_q == 4'h1) ? {4'h0, remain_q} : 32'h0;
      default: begin
        for (int i = 0; i < ppl_pkg::FEED_COUNT; i++)
          if (s_axi_araddr == ppl_pkg::OFS_FEED + 8'(4 * i))
            rd = {2'h0, feed_hi_q[i], 2'h0, feed_lo_q[i]};
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= ppl_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd;
      s_axi_rresp <= (s_axi_araddr > LAST_OFS) ? ppl_pkg::RESP_SLVERR
        : ppl_pkg::RESP_OKAY;
    end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
  end
  assign s_axi_arready = ~s_axi_rvalid;
endmodule : ppl_loop
`default_nettype wire

// >>> ppl_loop_sva.sv
`default_nettype none
// -------------------------------------------------------------
// port checker
// -------------------------------------------------------------
module ppl_loop_sva #(
  parameter int NTERM = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] speed_cmd,
  input wire logic [NTERM-1:0] out_terminal,
  input wire logic in_position_flag,
  input wire logic excess_error
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // a pending answer holds until taken
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid) else $error("no bvalid");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("no rvalid");
  // new requests refused while an answer waits
  a_write_refused: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken early");
  a_reset_idle: assert property ($rose(aresetn) |-> speed_cmd == 32'h0 &&
    !excess_error && !in_position_flag) else $error("outputs not idle");
  a_term_inpos: assert property (|out_terminal |->
    in_position_flag || $past(in_position_flag)) else $error("term w/o inpos");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_inpos: cover property ($rose(in_position_flag));
  c_excess: cover property ($rose(excess_error));
endmodule : ppl_loop_sva
bind ppl_loop ppl_loop_sva #(.NTERM(NTERM)) u_ppl_loop_sva (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .speed_cmd(speed_cmd),
  .out_terminal(out_terminal), .in_position_flag(in_position_flag),
  .excess_error(excess_error));
`default_nettype wire

// >>> ppl_motor.sv
`default_nettype none
// -------------------------------------------------------------
// motor and encoder model
// -------------------------------------------------------------
module ppl_motor (
  input wire logic aclk,
  input wire logic run,
  input wire logic [31:0] speed_cmd,
  output logic enc_pulse,
  output logic enc_dir
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] div_q = 4'h0;
  // one count per 16 cycles: slower than the speed update, so no overshoot
  always_ff @(posedge aclk) begin
    div_q <= div_q + 4'h1;
    enc_pulse <= run && div_q == 4'h0 && speed_cmd != 32'h0;
    enc_dir <= speed_cmd[31];
  end
endmodule : ppl_motor
`default_nettype wire

// >>> ppl_pkg.sv
`default_nettype none
package ppl_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00; // src sel, monitor sel
  localparam logic [7:0] OFS_GEAR = 8'h04; // numerator / denominator
  localparam logic [7:0] OFS_GAIN = 8'h08; // loop gain, ff gain
  localparam logic [7:0] OFS_FFTC = 8'h0c; // ff filter time, ms
  localparam logic [7:0] OFS_INPOS = 8'h10; // in-position width
  localparam logic [7:0] OFS_ERRLV = 8'h14; // excessive error level
  localparam logic [7:0] OFS_DECEL = 8'h18; // sudden stop decel, loop ticks (1 ms)
  localparam logic [7:0] OFS_TERM = 8'h1c; // terminal function codes
  localparam logic [7:0] OFS_STAT = 8'h20; // status, read only
  localparam logic [7:0] OFS_DROOP = 8'h24; // droop, read only
  localparam logic [7:0] OFS_SPEED = 8'h28; // speed command, read only
  localparam logic [7:0] OFS_MON = 8'h2c; // monitor value, read only
  localparam logic [7:0] OFS_FEED = 8'h40; // feed table, 15 words
  localparam int FEED_COUNT = 15;
  // ---------------------------------------------------------------
  // reset values and ranges
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_GEAR = 16'h0001;
  localparam logic [7:0] RST_KP = 8'h19; // 25 per second
  localparam logic [7:0] KP_MAX = 8'h96; // 150 per second
  localparam logic [7:0] FF_MAX = 8'h64; // 100 percent
  localparam logic [12:0] FFTC_MAX = 13'h1388; // 5000 ms
  localparam logic [14:0] RST_INPOS = 15'h0064; // 100 pulses
  localparam logic [18:0] RST_ERRLV = 19'h09c40; // 40K
  localparam logic [18:0] ERRLV_MAX = 19'h61a80; // 400K
  localparam logic [18:0] ERRLV_OFF = 19'h0270f; // 9999: check off
  localparam logic [13:0] DIGIT_MAX = 14'h270f; // 9999 per half
  localparam logic [13:0] DIGIT_SCALE = 14'h2710; // upper x 10000
  localparam logic [11:0] DECEL_MAX = 12'he10; // 3.6 s
  localparam logic [3:0] MON_OFF = 4'hf; // 9999 stored as 15
  localparam logic [7:0] FN_SERVO_ON = 8'h17; // function code 23
  localparam logic [7:0] FN_INPOS = 8'h24; // function code 36
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_US = 1000; // control loop period, 1 ms
  localparam int TICK_CYC = TICK_US * (CLK_HZ / 1_000_000);
  // contact inputs grouped
  typedef struct packed {
    logic fwd;
    logic rev;
    logic sel3;
    logic sel_high;
    logic sel_mid;
    logic sel_low;
  } ppl_contacts_t;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FEED = 3'b010,
    ST_STOP = 3'b100
  } ppl_state_t;
endpackage : ppl_pkg
`default_nettype wire

// >>> test_pulse_position_loop.sv
`default_nettype none
module test_pulse_position_loop;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 10;
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, brd = 1'b0;
  logic arv = 1'b0, rrd = 1'b0, cp = 1'b0, cdir = 1'b0, te = 1'b0;
  logic tdir = 1'b0, run = 1'b0, awr, wr_rdy, bv, arr, rv, inpos, exc;
  logic mp, md;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, spd, d;
  logic [3:0] tin = 4'h0, tout;
  logic [1:0] bresp, rresp, r;
  ppl_pkg::ppl_contacts_t ct = '0;
  int miscompares = 0;
  int num_checks = 0;
  // --------------------------------------------------------------
  // clock, design and motor
  // --------------------------------------------------------------
  always #5 aclk = ~aclk;
  ppl_loop #(.TICK(TK)) u_ppl_loop (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrd),
    .contacts(ct), .in_terminal(tin), .cmd_pulse(cp), .cmd_dir(cdir),
    .enc_pulse(mp | te), .enc_dir(te ? tdir : md), .speed_cmd(spd),
    .out_terminal(tout), .in_position_flag(inpos), .excess_error(exc));
  ppl_motor u_ppl_motor (.aclk(aclk), .run(run), .speed_cmd(spd),
    .enc_pulse(mp), .enc_dir(md));
  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic w(input int n);
    repeat (n) @(posedge aclk);
  endtask : w
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp
  // ready is peeked at the negedge, so the handshake edge is never raced
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ga, gw, gb;
    int n;
    gb = 1'b0;
    n = 0;
    @(posedge aclk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    while (!gb && n < 100) begin
      @(negedge aclk);
      ga = awv && awr;
      gw = wv && wr_rdy;
      gb = bv;
      @(posedge aclk);
      if (ga) awv <= 1'b0;
      if (gw) wv <= 1'b0;
      n++;
    end
    brd <= 1'b0;
    cmp({31'h0, gb}, 32'h1);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ga, gr;
    int n;
    gr = 1'b0;
    n = 0;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    while (!gr && n < 100) begin
      @(negedge aclk);
      ga = arv && arr;
      gr = rv;
      d = rdat;
      r = rresp;
      @(posedge aclk);
      if (ga) arv <= 1'b0;
      n++;
    end
    rrd <= 1'b0;
    cmp({31'h0, gr}, 32'h1);
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    cmp(d, e);
    cmp({30'h0, r}, {30'h0, ppl_pkg::RESP_OKAY});
  endtask : rc
  // command (enc=0) or encoder (enc=1) pulses, one per cycle
  task automatic burst(input int n, input logic dir, input logic enc);
    cdir <= dir;
    tdir <= dir;
    repeat (n) begin
      @(posedge aclk);
      if (enc) te <= 1'b1;
      else cp <= 1'b1;
    end
    @(posedge aclk);
    cp <= 1'b0;
    te <= 1'b0;
    w(4);
  endtask : burst
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // watchdog well beyond the expected run
  initial begin
    #400_000;
    miscompares++;
    wrap_up();
  end
  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial begin
    w(3);
    aresetn <= 1'b1;
    rc(ppl_pkg::OFS_CTRL, 32'h00000f00);
    rc(ppl_pkg::OFS_GEAR, 32'h00010001);
    rc(ppl_pkg::OFS_GAIN, 32'h00000019);
    rc(ppl_pkg::OFS_INPOS, 32'h00000064);
    rc(ppl_pkg::OFS_ERRLV, 32'h00009c40);
    rc(ppl_pkg::OFS_DECEL, 32'h00000000);
    rd(8'h7c);
    cmp({30'h0, r}, {30'h0, ppl_pkg::RESP_SLVERR});
    wr(ppl_pkg::OFS_GAIN, 32'h0000c8c8);
    rc(ppl_pkg::OFS_GAIN, 32'h00006496);
    wr(ppl_pkg::OFS_ERRLV, 32'h0007a120);
    rc(ppl_pkg::OFS_ERRLV, 32'h00061a80);
    wr(ppl_pkg::OFS_CTRL, 32'h00000700);
    rc(ppl_pkg::OFS_CTRL, 32'h00000f00);
    wr(ppl_pkg::OFS_FFTC, 32'h00001fff);
    rc(ppl_pkg::OFS_FFTC, 32'h00001388);
    wr(ppl_pkg::OFS_DECEL, 32'h00000fff);
    rc(ppl_pkg::OFS_DECEL, 32'h00000e10);
    $display("test settings done");
    // pulse train source, servo on terminal 0, in-position on terminal 1
    wr(ppl_pkg::OFS_GAIN, 32'h00000019);
    wr(ppl_pkg::OFS_ERRLV, 32'h00009c40);
    wr(ppl_pkg::OFS_CTRL, 32'h00000001);
    wr(ppl_pkg::OFS_TERM, 32'h00002417);
    tin <= 4'h1;
    ct.fwd <= 1'b1;
    ct.rev <= 1'b1;
    burst(99, 1'b0, 1'b0);
    rc(ppl_pkg::OFS_DROOP, 32'd99);
    cmp({31'h0, inpos}, 32'h1);
    cmp({28'h0, tout}, 32'h2);
    burst(1, 1'b0, 1'b0);
    cmp({31'h0, inpos}, 32'h0);
    w(3 * TK);
    cmp(spd, 32'd2500);
    rc(ppl_pkg::OFS_MON, 32'd100);
    burst(40, 1'b0, 1'b1);
    rc(ppl_pkg::OFS_DROOP, 32'd60);
    wr(ppl_pkg::OFS_GEAR, 32'h00010002);
    burst(10, 1'b0, 1'b0);
    rc(ppl_pkg::OFS_DROOP, 32'd80);
    wr(ppl_pkg::OFS_GEAR, 32'h00000002);
    burst(10, 1'b0, 1'b0);
    rc(ppl_pkg::OFS_DROOP, 32'd80);
    wr(ppl_pkg::OFS_GEAR, 32'h00010001);
    ct.rev <= 1'b0;
    burst(10, 1'b1, 1'b0);
    rc(ppl_pkg::OFS_DROOP, 32'd80);
    ct.rev <= 1'b1;
    burst(130, 1'b1, 1'b0);
    rc(ppl_pkg::OFS_DROOP, 32'hffffffce);
    cmp({31'h0, inpos}, 32'h1);
    $display("test pulse train done");
    // excessive error, sticky until servo off, 9999 disables it
    wr(ppl_pkg::OFS_ERRLV, 32'd30);
    burst(90, 1'b0, 1'b0);
    cmp({31'h0, exc}, 32'h1);
    tin <= 4'h0;
    w(4);
    cmp({31'h0, exc}, 32'h0);
    tin <= 4'h1;
    wr(ppl_pkg::OFS_ERRLV, 32'd9999);
    wr(ppl_pkg::OFS_GEAR, 32'h0001012c);
    burst(40, 1'b0, 1'b0);
    cmp({31'h0, exc}, 32'h0);
    burst(40, 1'b1, 1'b0);
    wr(ppl_pkg::OFS_GEAR, 32'h00010001);
    // leave some droop for the motor model to drain
    burst(50, 1'b0, 1'b0);
    run <= 1'b1;
    w(1500);
    run <= 1'b0;
    rc(ppl_pkg::OFS_DROOP, 32'd0);
    w(3 * TK);
    cmp(spd, 32'd0);
    $display("test excess and drain done");
    // stored feed amounts through contact inputs
    wr(ppl_pkg::OFS_CTRL, 32'h00000000);
    for (int i = 0; i < ppl_pkg::FEED_COUNT; i++) begin
      wr(ppl_pkg::OFS_FEED + 8'(4 * i), 32'd40);
    end
    wr(ppl_pkg::OFS_FEED + 8'h38, 32'h3fff3fff);
    rc(ppl_pkg::OFS_FEED + 8'h38, 32'h270f270f);
    ct <= '{fwd: 1'b0, rev: 1'b0, sel3: 1'b0, sel_high: 1'b0,
      sel_mid: 1'b1, sel_low: 1'b1};
    w(4);
    ct.fwd <= 1'b1;
    w(80);
    rc(ppl_pkg::OFS_DROOP, 32'd40);
    ct.sel_low <= 1'b0;
    w(80);
    rc(ppl_pkg::OFS_DROOP, 32'd40);
    ct.fwd <= 1'b0;
    ct.sel_low <= 1'b1;
    w(4);
    ct.fwd <= 1'b1;
    w(80);
    rc(ppl_pkg::OFS_DROOP, 32'd80);
    ct.fwd <= 1'b0;
    ct.rev <= 1'b1;
    w(80);
    rc(ppl_pkg::OFS_DROOP, 32'd40);
    $display("test stored feed done");
    wrap_up();
  end
endmodule : test_pulse_position_loop
`default_nettype wire
